// [chsc_host_port.sv]
// Purpose: Host strobe decode, resource routing and segment counters of the CAM
// Assumes: Strobes are synchronous to clk; a cycle is one low phase of chipEnableN
// Notes:   dqOeN is low while the port drives the data bus
`timescale 1ns/1ps
module chsc_host_port
    import chsc_pkg::*;
#(
    parameter int MEM_WORDS = 16,
    parameter int AW = 4,
    parameter logic [7:0] DEVICE_ID = 8'h5A // Arbitrary identification value
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Host strobes
    input wire logic chipEnableN,
    input wire logic writeN,
    input wire logic command_select_n,
    // Data bus
    input wire logic [15:0] dqIn,
    output logic [15:0] dqOut,
    output logic dqOeN,
    // Device state
    output logic registerBank,
    output logic [1:0] operatingMode
);
    // =========================================================================
    // State
    logic ePrev, readActive, statusHigh, addrPending, bank, stepSrc, stepDst;
    logic next_readActive, next_statusHigh, next_addrPending, next_bank;
    logic next_stepSrc, next_stepDst;
    chsc_tco_t one_shot_register_override, next_tco;
    logic [15:0] ctrl [2], segc [2], addr [2];
    logic [15:0] next_ctrl [2], next_segc [2], next_addr [2];
    chsc_res_t psrc [2], pdst [2], next_psrc [2], next_pdst [2];
    logic [15:0] page_address_value, device_select_value, next_free_pointer;
    logic [15:0] next_pa, next_ds, lastSps, lastSpd, next_lastSps, next_lastSpd;
    logic [15:0] next_dqOut;
    logic [63:0] comparand, mask_one, mask_two, next_cmp, next_m1, next_m2;
    logic [63:0] mem [MEM_WORDS];
    logic [1:0] memValid [MEM_WORDS];
    logic [1:0] lastValid, next_lastValid;
    logic memWe, softReset;
    logic [AW-1:0] memIdx;
    logic [63:0] memData;
    logic fall, rise, selected, wrOk;
    logic [1:0] srcSeg, dstSeg;

    // Cycle edges and device selection
    assign fall = ePrev & ~chipEnableN;
    assign rise = ~ePrev & chipEnableN;
    assign selected = device_select_value == page_address_value;
    assign wrOk = selected | (device_select_value == ALL_ONES);
    assign srcSeg = segc[bank][SRC_CUR +: 2];
    assign dstSeg = segc[bank][DST_CUR +: 2];
    assign dqOeN = ~(readActive & ~chipEnableN);
    assign registerBank = bank;
    assign operatingMode = ctrl[bank][1:0];
    assign next_free_pointer = 16'h0000;

    // Segment counter step: wrap past three, reload start after end
    function automatic logic [1:0] segStep(input logic [1:0] cur, input logic [1:0] lim,
                                           input logic [1:0] start);
        logic [1:0] r;
        r = (cur == lim) ? start : 2'(cur + 2'h1);
        return r;
    endfunction : segStep

    // Memory index of a persistent memory resource
    function automatic logic [AW-1:0] memSel(input chsc_res_t r, input logic [15:0] ar,
                                              input logic [15:0] nf);
        logic [AW-1:0] i;
        i = (r == RES_MEM_NF) ? nf[AW-1:0] : ar[AW-1:0];
        return i;
    endfunction : memSel

    // Next-state computation for the whole port
    always_comb begin
        logic [63:0] res;
        logic [15:0] rd;
        logic isRead, isCmd;
        chsc_res_t r;
        res = 64'h0;
        rd = 16'h0000;
        r = RES_CMP;
        isRead = writeN;
        isCmd = ~command_select_n;
        next_readActive = readActive;
        next_statusHigh = statusHigh;
        next_addrPending = addrPending;
        next_bank = bank;
        next_tco = one_shot_register_override;
        next_ctrl = ctrl;
        next_segc = segc;
        next_addr = addr;
        next_psrc = psrc;
        next_pdst = pdst;
        next_pa = page_address_value;
        next_ds = device_select_value;
        next_lastSps = lastSps;
        next_lastSpd = lastSpd;
        next_lastValid = lastValid;
        next_cmp = comparand;
        next_m1 = mask_one;
        next_m2 = mask_two;
        next_dqOut = dqOut;
        next_stepSrc = stepSrc;
        next_stepDst = stepDst;
        memWe = 1'b0;
        memIdx = '0;
        memData = 64'h0;
        softReset = 1'b0;
        if (rise) begin
            // Counters advance at the end of a data cycle
            next_readActive = 1'b0;
            next_stepSrc = 1'b0;
            next_stepDst = 1'b0;
            if (stepSrc) begin
                next_segc[bank][SRC_CUR +: 2] = segStep(srcSeg, segc[bank][SRC_END +: 2],
                                                       segc[bank][SRC_START +: 2]);
            end
            if (stepDst) begin
                next_segc[bank][DST_CUR +: 2] = segStep(dstSeg, segc[bank][DST_END +: 2],
                                                       segc[bank][DST_START +: 2]);
            end
        end else if (fall && isCmd && !isRead) begin
            // Command write
            next_statusHigh = 1'b0;
            next_tco = TCO_NONE;
            if (one_shot_register_override == TCO_DS) begin
                next_ds = dqIn;
            end else if (!wrOk) begin
                next_tco = TCO_NONE;
            end else if (addrPending) begin
                next_addr[bank] = dqIn;
                next_addrPending = 1'b0;
            end else if (one_shot_register_override == TCO_CT) begin
                if (!dqIn[CT_RESET_BIT]) begin
                    softReset = 1'b1;
                end else begin
                    next_ctrl[bank] = dqIn;
                end
            end else if (one_shot_register_override == TCO_PA) begin
                next_pa = dqIn;
            end else if (one_shot_register_override == TCO_SC) begin
                next_segc[bank] = dqIn & ~SEGC_ZERO_MASK;
            end else if (one_shot_register_override == TCO_AR) begin
                next_addr[bank] = dqIn;
            end else if (one_shot_register_override != TCO_NONE) begin
                next_tco = TCO_NONE;
            end else if (dqIn[ADDR_FLAG_BIT]) begin
                next_addrPending = 1'b1;
            end else begin
                // Instruction decoder load
                case (dqIn[15:8])
                    OP_TCO: next_tco = chsc_tco_t'(dqIn[3:0]);
                    OP_SPS: begin
                        next_psrc[bank] = chsc_res_t'(dqIn[2:0]);
                        next_lastSps = dqIn;
                    end
                    OP_SPD: begin
                        next_pdst[bank] = chsc_res_t'(dqIn[2:0]);
                        next_lastSpd = dqIn;
                    end
                    OP_BANK: next_bank = dqIn[0];
                    OP_RSC: begin
                        next_segc[bank][SRC_CUR +: 2] = segc[bank][SRC_START +: 2];
                        next_segc[bank][DST_CUR +: 2] = segc[bank][DST_START +: 2];
                    end
                    default: next_tco = TCO_NONE;
                endcase
            end
        end else if (fall && isCmd && isRead) begin
            // Command read
            next_tco = TCO_NONE;
            next_statusHigh = 1'b0;
            case (one_shot_register_override)
                TCO_NF: rd = next_free_pointer;
                TCO_AR: rd = addr[bank];
                TCO_CT: rd = ctrl[bank] & ~ALL_ONES[CT_RESET_BIT:0] | (ctrl[bank] & 16'h7FFF);
                TCO_PA: rd = page_address_value;
                TCO_SC: rd = segc[bank] & ~SEGC_ZERO_MASK;
                TCO_DS: rd = device_select_value;
                READ_SOURCE_SELECTION: rd = {DEVICE_ID, lastSps[7:0]};
                READ_DESTINATION_SELECTION: rd = lastSpd;
                default: begin
                    rd = statusHigh ? {2'h3, lastValid, 12'hFFF} : ALL_ONES;
                    next_statusHigh = ~statusHigh;
                end
            endcase
            next_readActive = selected;
            next_dqOut = rd;
        end else if (fall && !isRead) begin
            // Data write to the persistent destination
            next_statusHigh = 1'b0;
            r = pdst[bank];
            if (wrOk) begin
                next_stepDst = 1'b1;
                case (r)
                    RES_CMP: next_cmp[dstSeg*16 +: 16] = dqIn;
                    RES_MASK1: next_m1[dstSeg*16 +: 16] = dqIn;
                    RES_MASK2: next_m2[dstSeg*16 +: 16] = dqIn;
                    RES_MEM_AR, RES_MEM_NF: begin
                        memWe = 1'b1;
                        memIdx = memSel(r, addr[bank], next_free_pointer);
                        memData = mem[memIdx];
                        memData[dstSeg*16 +: 16] = dqIn;
                    end
                    default: next_stepDst = 1'b1;
                endcase
            end
        end else if (fall) begin
            // Data read from the persistent source
            next_statusHigh = 1'b0;
            r = psrc[bank];
            memIdx = memSel(r, addr[bank], next_free_pointer);
            case (r)
                RES_CMP: res = comparand;
                RES_MASK1: res = mask_one;
                RES_MASK2: res = mask_two;
                default: begin
                    res = mem[memIdx];
                    next_lastValid = memValid[memIdx];
                end
            endcase
            next_readActive = selected;
            next_stepSrc = selected;
            next_dqOut = res[srcSeg*16 +: 16];
        end
    end

    // Register update with hard and soft reset
    always_ff @(posedge clk) begin
        ePrev <= reset ? 1'b1 : chipEnableN;
        if (reset || softReset) begin
            readActive <= 1'b0;
            statusHigh <= 1'b0;
            addrPending <= 1'b0;
            bank <= 1'b0;
            one_shot_register_override <= TCO_NONE;
            stepSrc <= 1'b0;
            stepDst <= 1'b0;
            for (int b = 0; b < 2; b++) begin
                ctrl[b] <= CTRL_RESET;
                segc[b] <= SEGC_RESET;
                addr[b] <= 16'h0000;
                psrc[b] <= RES_CMP;
                pdst[b] <= RES_CMP;
            end
            lastSps <= 16'h0000;
            lastSpd <= 16'h0000;
            lastValid <= VALID_AFTER_RESET;
            comparand <= 64'h0;
            mask_one <= 64'h0;
            mask_two <= 64'h0;
            dqOut <= 16'h0000;
            for (int i = 0; i < MEM_WORDS; i++) begin
                memValid[i] <= VALID_EMPTY;
            end
            if (reset) begin
                page_address_value <= 16'h0000;
                device_select_value <= 16'h0000;
            end
        end else begin
            readActive <= next_readActive;
            statusHigh <= next_statusHigh;
            addrPending <= next_addrPending;
            bank <= next_bank;
            one_shot_register_override <= next_tco;
            stepSrc <= next_stepSrc;
            stepDst <= next_stepDst;
            ctrl <= next_ctrl;
            segc <= next_segc;
            addr <= next_addr;
            psrc <= next_psrc;
            pdst <= next_pdst;
            page_address_value <= next_pa;
            device_select_value <= next_ds;
            lastSps <= next_lastSps;
            lastSpd <= next_lastSpd;
            lastValid <= next_lastValid;
            comparand <= next_cmp;
            mask_one <= next_m1;
            mask_two <= next_m2;
            dqOut <= next_dqOut;
            if (memWe) begin
                mem[memIdx] <= memData;
            end
        end
    end

    // =========================================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    scReadZero_a: assert property (fall && !command_select_n && writeN && one_shot_register_override == TCO_SC
        |=> (dqOut & SEGC_ZERO_MASK) == 16'h0000) else $error("segment control zero bits set");
    busFloat_a: assert property (fall && !writeN |=> dqOeN)
        else $error("bus driven during write cycle");
    dstReload_a: assert property (rise && stepDst && dstSeg == segc[bank][DST_END +: 2]
        |=> segc[bank][DST_CUR +: 2] == segc[bank][DST_START +: 2]) else $error("no reload");
    restartSeg_a: assert property (fall && !command_select_n && !writeN && wrOk
        && one_shot_register_override == TCO_NONE && !addrPending && dqIn == {OP_RSC, 8'h00}
        |=> srcSeg == segc[bank][SRC_START +: 2] && dstSeg == segc[bank][DST_START +: 2])
        else $error("restart did not reload counters");
    resetSeg_a: assert property (@(posedge clk) disable iff (1'b0) reset |=> segc[0] == SEGC_RESET
        && ctrl[0] == CTRL_RESET && !bank) else $error("reset values wrong");
    statusHigh_a: assert property (fall && !command_select_n && writeN && one_shot_register_override == TCO_NONE
        && !statusHigh ##1 !fall [*1] |-> statusHigh) else $error("status half not armed");
    deselRead_a: assert property (fall && writeN && !wrOk
        |=> dqOeN [*2]) else $error("deselected device drove bus");
    oneShot_a: assert property (fall && !command_select_n && one_shot_register_override != TCO_NONE && !softReset
        |=> one_shot_register_override == TCO_NONE) else $error("override outlived one command cycle");
    addrFlag_a: assert property (fall && !command_select_n && !writeN && wrOk
        && one_shot_register_override == TCO_NONE && !addrPending && dqIn[ADDR_FLAG_BIT] |=> addrPending)
        else $error("address flag not captured");
endmodule : chsc_host_port

// [chsc_pkg.sv]
// Purpose: Constants and types for the CAM host cycle and segment control port
// Assumes: 16-bit data bus, 64-bit resources split into four 16-bit segments
// Notes:   Instruction opcodes and field layouts are fixed here for the whole block
// =============================================================================
// Overview of operation
// - segment control reads bits 15,10,5,2 as zero
// - only active set's segment control is accessed
// - separate read and write segment counters
// - counters hold start, end and free current value
// - count up to end, then reload start
// - above end: count to three, wrap, continue
// - restart instruction reloads both currents from starts
// - reset gives start 0, end 3, current 0
// - chip and command select decode command cycles
// - command select high gives persistent data cycles
// - command write loads instruction decoder by default
// - address flag routes next command write to address
// - override lasts one command cycle, next-free never loaded
// - second consecutive status read returns upper half
// - comparand is default source and destination
// - page mismatch ignores cycles; all-ones allows writes only
// - selection readback gives decoder bits, source adds id
// - reset marks every memory location empty
// - reset sets flags on, masking and translation off
// - control register reads 0008H after reset
// - hard reset clears pointers; soft keeps page, select
// - reset selects the foreground register set
// - reset enters standard operating mode
// - segment counters advance when chip enable rises
package chsc_pkg;
    // =========================================================================
    // Instruction encoding (upper byte opcode, low nibble operand)
    localparam logic [7:0] OP_TCO = 8'h02;
    localparam logic [7:0] OP_SPS = 8'h04;
    localparam logic [7:0] OP_SPD = 8'h05;
    localparam logic [7:0] OP_BANK = 8'h06;
    localparam logic [7:0] OP_RSC = 8'h07;
    localparam int ADDR_FLAG_BIT = 11;
    localparam int CT_RESET_BIT = 15;
    // =========================================================================
    // Reset values
    localparam logic [15:0] CTRL_RESET = 16'h0008;
    localparam logic [15:0] SEGC_RESET = 16'h1818;
    localparam logic [15:0] SEGC_ZERO_MASK = 16'h8424;
    localparam logic [15:0] ALL_ONES = 16'hFFFF;
    localparam logic [1:0] VALID_EMPTY = 2'h2;
    localparam logic [1:0] VALID_AFTER_RESET = 2'h3;
    localparam logic [1:0] SEG_LAST = 2'h3;
    // =========================================================================
    // Segment control field positions (low bit of each 2-bit field)
    localparam int SRC_CUR = 0;
    localparam int SRC_END = 3;
    localparam int SRC_START = 6;
    localparam int DST_CUR = 8;
    localparam int DST_END = 11;
    localparam int DST_START = 13;
    // =========================================================================
    // One-shot override targets
    typedef enum logic [3:0] {
        TCO_NONE = 4'h0, TCO_CT = 4'h1, TCO_PA = 4'h2, TCO_SC = 4'h3, TCO_AR = 4'h4,
        TCO_NF = 4'h5, TCO_DS = 4'h6, READ_SOURCE_SELECTION = 4'h7, READ_DESTINATION_SELECTION = 4'h8
    } chsc_tco_t;
    // Persistent resources
    typedef enum logic [2:0] {
        RES_CMP = 3'h0, RES_MASK1 = 3'h1, RES_MASK2 = 3'h2, RES_MEM_AR = 3'h3,
        RES_MEM_NF = 3'h4, RES_MEM_HPM = 3'h5
    } chsc_res_t;
endpackage : chsc_pkg

// [chsc_host_model.sv]
// =============================================================================
// Purpose: Host processor model driving the CAM port strobes and shared data bus
// Assumes: One host cycle is one low phase of chipEnableN; strobes move after clk rises
// Notes:   A bus that nobody drives shows a value that flips every clock
`timescale 1ns/1ps
module chsc_host_model (
    // Clock
    input wire logic clk,
    // Strobes and bus toward the port
    output logic chipEnableN,
    output logic writeN,
    output logic command_select_n,
    output logic [15:0] dqIn,
    // Port read side
    input wire logic [15:0] dqOut,
    input wire logic dqOeN
);
    logic hostDrive;
    logic [15:0] hostData;
    logic [15:0] lastBus;

    // =========================================================================
    // Bus level: port when enabled, host on writes, otherwise a toggling pattern
    assign dqIn = !dqOeN ? dqOut : (hostDrive ? hostData : ~lastBus);

    always @(posedge clk) begin
        lastBus <= dqIn;
    end

    // Idle strobes from time zero
    initial begin
        chipEnableN = 1'b1;
        writeN = 1'b1;
        command_select_n = 1'b1;
        hostDrive = 1'b0;
        hostData = 16'h0000;
        lastBus = 16'h0000;
    end

    // =========================================================================
    // One host cycle; read data and enable are taken at the edge before release
    task automatic cycle(input logic cmdN, input logic wrN, input logic [15:0] d,
                         output logic [15:0] rd, output logic oeN);
        @(posedge clk);
        chipEnableN <= 1'b0;
        command_select_n <= cmdN;
        writeN <= wrN;
        hostData <= d;
        hostDrive <= ~wrN;
        repeat (3) @(posedge clk);
        rd = dqOut;
        oeN = dqOeN;
        chipEnableN <= 1'b1;
        hostDrive <= 1'b0;
        @(posedge clk);
    endtask : cycle
endmodule : chsc_host_model

// [tb_cam_host_cycle_and_segment_control.sv]
// =============================================================================
// Purpose: Self-checking bench for the CAM host cycle and segment control port
// Assumes: chsc_host_model runs each host cycle; expectations come from reset values and the data written
// Notes:   Row table first, then bank, select, soft and hard reset cases by hand
`timescale 1ns/1ps
module tb_cam_host_cycle_and_segment_control;
    import chsc_pkg::*;
    typedef struct {
        logic c;
        logic w;
        logic [15:0] d;
        logic [15:0] e;
        logic [1:0] k;
    } chsc_row_t;
    localparam logic CMD = 1'b0;
    localparam logic DAT = 1'b1;
    localparam logic WR = 1'b0;
    localparam logic RD = 1'b1;
    localparam logic [1:0] NC = 2'h0;
    localparam logic [1:0] CK = 2'h1;
    localparam logic [1:0] OFF = 2'h2;
    localparam logic [7:0] ID = 8'h3C; // Arbitrary identification value
    localparam int LIMIT = 2000;
    logic clk;
    logic reset;
    logic chipEnableN;
    logic writeN;
    logic command_select_n;
    logic [15:0] dqIn;
    logic [15:0] dqOut;
    logic dqOeN;
    logic registerBank;
    logic [1:0] operatingMode;
    logic [15:0] zeroRegs[4] = '{16'h0202, 16'h0204, 16'h0205, 16'h0206};
    int miscompares = 0;
    int cmpCount = 0;
    int cycles = 0;
    chsc_row_t rows[$];

    // =========================================================================
    // Port and host
    chsc_host_port #(.DEVICE_ID(ID)) i_chsc_host_port (.clk(clk), .reset(reset),
        .chipEnableN(chipEnableN), .writeN(writeN), .command_select_n(command_select_n),
        .dqIn(dqIn), .dqOut(dqOut), .dqOeN(dqOeN), .registerBank(registerBank),
        .operatingMode(operatingMode));
    chsc_host_model i_chsc_host_model (.clk(clk), .chipEnableN(chipEnableN),
        .writeN(writeN), .command_select_n(command_select_n), .dqIn(dqIn),
        .dqOut(dqOut), .dqOeN(dqOeN));

    // Clock and hang limit
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            conclude();
        end
    end

    // =========================================================================
    // Compare tasks and verdict
    task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmpCount++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check16
    task automatic checkBit(input string what, input logic exp, input logic got);
        cmpCount++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : checkBit
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmpCount, miscompares);
        if (miscompares == 0 && cmpCount > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    // =========================================================================
    // Cycle runner, row builder and reset
    task automatic step(input logic c, input logic w, input logic [15:0] d,
                        input logic [15:0] e, input logic [1:0] k);
        logic [15:0] rd;
        logic oe;
        i_chsc_host_model.cycle(c, w, d, rd, oe);
        if (k == CK) begin
            check16("read data", e, rd);
            checkBit("bus enable", 1'b0, oe);
        end else if (k == OFF) begin
            checkBit("bus enable", 1'b1, oe);
        end
    endtask : step
    task automatic row(input logic c, input logic w, input logic [15:0] d,
                       input logic [15:0] e, input logic [1:0] k);
        rows.push_back('{c, w, d, e, k});
    endtask : row
    task automatic hardReset();
        reset <= 1'b1;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
    endtask : hardReset

    // =========================================================================
    // Main sequence
    initial begin
        reset = 1'b1;
        // Reset values, status halves, cleared pointers
        row(CMD, WR, 16'h0203, 16'h0000, NC);
        row(CMD, RD, 16'h0000, SEGC_RESET, CK);
        row(CMD, WR, 16'h0201, 16'h0000, NC);
        row(CMD, RD, 16'h0000, CTRL_RESET, CK);
        row(CMD, RD, 16'h0000, 16'hFFFF, CK);
        row(CMD, RD, 16'h0000, 16'hFFFF, CK);
        foreach (zeroRegs[i]) begin
            row(CMD, WR, zeroRegs[i], 16'h0000, NC);
            row(CMD, RD, 16'h0000, 16'h0000, CK);
        end
        // Comparand as default data target, four segments in order
        for (int i = 0; i < 4; i++) begin
            row(DAT, WR, 16'(16'h1111 * (i + 1)), 16'h0000, NC);
        end
        for (int i = 0; i < 4; i++) begin
            row(DAT, RD, 16'h0000, 16'(16'h1111 * (i + 1)), CK);
        end
        // Selection readback, then comparand restored
        row(CMD, WR, 16'h0401, 16'h0000, NC);
        row(CMD, WR, 16'h0207, 16'h0000, NC);
        row(CMD, RD, 16'h0000, {ID, 8'h01}, CK);
        row(CMD, WR, 16'h0502, 16'h0000, NC);
        row(CMD, WR, 16'h0208, 16'h0000, NC);
        row(CMD, RD, 16'h0000, 16'h0502, CK);
        row(CMD, WR, 16'h0400, 16'h0000, NC);
        row(CMD, WR, 16'h0500, 16'h0000, NC);
        // Zero bits of segment control
        row(CMD, WR, 16'h0203, 16'h0000, NC);
        row(CMD, WR, 16'hFFFF, 16'h0000, NC);
        row(CMD, WR, 16'h0203, 16'h0000, NC);
        row(CMD, RD, 16'h0000, 16'h7BDB, CK);
        // Start 1, end 2, current 3: segments 3,0,1,2,1
        row(CMD, WR, 16'h0203, 16'h0000, NC);
        row(CMD, WR, 16'h3353, 16'h0000, NC);
        for (int i = 0; i < 5; i++) begin
            row(DAT, WR, 16'(16'hA000 + i), 16'h0000, NC);
        end
        row(CMD, WR, 16'h0203, 16'h0000, NC);
        row(CMD, RD, 16'h0000, 16'h3253, CK);
        row(CMD, WR, 16'h0700, 16'h0000, NC);
        row(CMD, WR, 16'h0203, 16'h0000, NC);
        row(CMD, RD, 16'h0000, 16'h3151, CK);
        row(DAT, RD, 16'h0000, 16'hA004, CK);
        row(DAT, RD, 16'h0000, 16'hA003, CK);
        row(DAT, RD, 16'h0000, 16'hA004, CK);
        // Address flag routing and one-shot override
        row(CMD, WR, 16'h0800, 16'h0000, NC);
        row(CMD, WR, 16'h0005, 16'h0000, NC);
        row(CMD, WR, 16'h0204, 16'h0000, NC);
        row(CMD, RD, 16'h0000, 16'h0005, CK);
        row(CMD, RD, 16'h0000, 16'hFFFF, CK);
        row(CMD, WR, 16'h0205, 16'h0000, NC);
        row(CMD, WR, 16'h0007, 16'h0000, NC);
        row(CMD, WR, 16'h0205, 16'h0000, NC);
        row(CMD, RD, 16'h0000, 16'h0000, CK);
        hardReset();
        foreach (rows[i]) begin
            step(rows[i].c, rows[i].w, rows[i].d, rows[i].e, rows[i].k);
        end
        $display("Test row table done");
        // Background set keeps its own segment control
        step(CMD, WR, 16'h0601, 16'h0000, NC);
        checkBit("register bank", 1'b1, registerBank);
        step(CMD, WR, 16'h0203, 16'h0000, NC);
        step(CMD, RD, 16'h0000, SEGC_RESET, CK);
        step(CMD, WR, 16'h0600, 16'h0000, NC);
        step(CMD, WR, 16'h0203, 16'h0000, NC);
        step(CMD, RD, 16'h0000, 16'h3152, CK);
        $display("Test register bank done");
        // Broadcast select, soft reset, then deselect
        step(CMD, WR, 16'h0206, 16'h0000, NC);
        step(CMD, WR, 16'hFFFF, 16'h0000, NC);
        step(CMD, RD, 16'h0000, 16'h0000, OFF);
        step(CMD, WR, 16'h0202, 16'h0000, NC);
        step(CMD, WR, 16'h0001, 16'h0000, NC);
        step(CMD, WR, 16'h0201, 16'h0000, NC);
        step(CMD, WR, 16'h0000, 16'h0000, NC);
        step(CMD, WR, 16'h0206, 16'h0000, NC);
        step(CMD, WR, 16'h0001, 16'h0000, NC);
        step(CMD, WR, 16'h0202, 16'h0000, NC);
        step(CMD, RD, 16'h0000, 16'h0001, CK);
        step(CMD, WR, 16'h0203, 16'h0000, NC);
        step(CMD, RD, 16'h0000, SEGC_RESET, CK);
        step(CMD, WR, 16'h0206, 16'h0000, NC);
        step(CMD, WR, 16'h0002, 16'h0000, NC);
        step(CMD, RD, 16'h0000, 16'h0000, OFF);
        step(DAT, RD, 16'h0000, 16'h0000, OFF);
        $display("Test select and soft reset done");
        // Hard reset in mid-run clears page address
        hardReset();
        step(CMD, WR, 16'h0202, 16'h0000, NC);
        step(CMD, RD, 16'h0000, 16'h0000, CK);
        checkBit("register bank", 1'b0, registerBank);
        check16("operating mode", 16'h0000, {14'h0000, operatingMode});
        $display("Test hard reset done");
        // Memory at address as destination and source, then validity in status
        step(CMD, WR, 16'h0503, 16'h0000, NC);
        for (int i = 0; i < 4; i++) begin
            step(DAT, WR, 16'(16'hC000 + i), 16'h0000, NC);
        end
        step(CMD, WR, 16'h0403, 16'h0000, NC);
        for (int i = 0; i < 4; i++) begin
            step(DAT, RD, 16'h0000, 16'(16'hC000 + i), CK);
        end
        step(CMD, RD, 16'h0000, 16'hFFFF, CK);
        step(CMD, RD, 16'h0000, {2'h3, VALID_EMPTY, 12'hFFF}, CK);
        $display("Test memory path done");
        conclude();
    end
endmodule : tb_cam_host_cycle_and_segment_control
